// [hdl/tap_pkg.sv]
// constants and types shared by the test access port block
package tap_pkg;
   // ------------------------------------------------------------
   // pins, widths
   // ------------------------------------------------------------
   localparam int PIN_TCK = 0;
   localparam int PIN_TMS = 1;
   localparam int PIN_TDI = 2;
   localparam int PIN_TDO = 3;
   localparam int ADDR_W = 8;
   localparam logic [3:0] TAP_PULLUPS = 4'h7;
   // ------------------------------------------------------------
   // instructions and data register tops
   // ------------------------------------------------------------
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] OP_IDCODE = 4'h1;
   localparam logic [3:0] OP_COMM = 4'h8;
   localparam logic [3:0] OP_BRKCFG = 4'h9;
   localparam logic [3:0] OP_BYPASS = 4'hF;
   localparam logic [4:0] TOP_ID = 5'h1F;
   localparam logic [4:0] TOP_BYTE = 5'h07;
   localparam logic [4:0] TOP_BYP = 5'h00;
   localparam int TMS_RESET_RUN = 5;
   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_FUSE = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_COMM = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_BRK = 8'h0C;
   localparam logic [3:0] FUSE_RESET = 4'h1;
   localparam int FUSE_TPE = 0;
   localparam int FUSE_DBG = 1;
   localparam int FUSE_LB1 = 2;
   localparam int FUSE_LB2 = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // break config: bit0 flow change, bit1 single step, bits 4:2 combined mode
   localparam int BRK_MODE_LSB = 2;
   localparam logic [2:0] MODE_FOUR_PROG = 3'h0;
   localparam logic [2:0] MODE_THREE_ONE = 3'h1;
   localparam logic [2:0] MODE_TWO_TWO = 3'h2;
   localparam logic [2:0] MODE_PROG_RANGE = 3'h3;
   localparam logic [2:0] MODE_DATA_RANGE = 3'h4;
   // ------------------------------------------------------------
   // controller states
   // ------------------------------------------------------------
   typedef enum logic [15:0] {
      TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
      SH_DR = 16'h0010, EX1_DR = 16'h0020, PAU_DR = 16'h0040, EX2_DR = 16'h0080,
      UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
      EX1_IR = 16'h1000, PAU_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
   } tap_state_t;
endpackage

// [hdl/sync_2ff.sv]
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// [hdl/axil_slave.sv]
// axi4-lite slave handshakes feeding a simple register strobe port
`timescale 1ns/1ns
`default_nettype none
module axil_slave import tap_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_hit,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic rd_hit,
   input wire logic [31:0] rd_word
);
   logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [ADDR_W-1:0] a_q, a_d;
   logic [31:0] dat_q, dat_d, rd_q, rd_d;
   logic [3:0] st_q, st_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;

   assign awready = !aw_q;
   assign wready = !w_q;
   assign arready = !r_q;
   assign bvalid = b_q;
   assign bresp = br_q;
   assign rvalid = r_q;
   assign rresp = rr_q;
   assign rdata = rd_q;
   assign rd_addr = araddr;
   assign wr_addr = a_q;
   assign wr_data = dat_q;
   assign wr_strb = st_q;
   // address and data are held until both are here and no answer waits
   assign wr_en = aw_q && w_q && !b_q;

   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      a_d = a_q;
      dat_d = dat_q;
      st_d = st_q;
      b_d = b_q && !bready;
      br_d = br_q;
      if (awvalid && !aw_q) begin
         aw_d = 1'h1;
         a_d = awaddr;
      end
      if (wvalid && !w_q) begin
         w_d = 1'h1;
         dat_d = wdata;
         st_d = wstrb;
      end
      if (wr_en) begin
         aw_d = 1'h0;
         w_d = 1'h0;
         b_d = 1'h1;
         br_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      r_d = r_q && !rready;
      rd_d = rd_q;
      rr_d = rr_q;
      if (arvalid && !r_q) begin
         r_d = 1'h1;
         rd_d = rd_hit ? rd_word : '0;
         rr_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_q <= 1'h0;
         w_q <= 1'h0;
         b_q <= 1'h0;
         r_q <= 1'h0;
         a_q <= '0;
         dat_q <= '0;
         st_q <= '0;
         br_q <= RESP_OKAY;
         rr_q <= RESP_OKAY;
         rd_q <= '0;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         b_q <= b_d;
         r_q <= r_d;
         a_q <= a_d;
         dat_q <= dat_d;
         st_q <= st_d;
         br_q <= br_d;
         rr_q <= rr_d;
         rd_q <= rd_d;
      end
   end
endmodule
`default_nettype wire

// [hdl/jtag_tap_debug_port.sv]
// test access port controller with debug link and register slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - sixteen states, stepped by TMS at TCK rise
// - power-on reset starts in Test-Logic-Reset
// - every shift path moves LSB first
// - four-bit instruction, top bit on exit
// - Shift-IR sends captured value 0x01
// - 1,1,0 returns; Update-IR loads instruction
// - instruction selects data register and logic
// - Shift-DR sends values from Capture-DR
// - latched outputs change only in Update-DR; break config also clears while debug is locked out
// - five TMS-high periods reach Test-Logic-Reset
// - no TRST; reset by power, fuse, TMS
// - fuse clear: port pins, controller held reset
// - fuse set: inputs pulled high, port enabled
// - debug needs fuse and no lock bits
// - break unit: flow, step, four breakpoints
// - processor results reach port via mapped word
// - Run-Test/Idle optional; actions may run there
// - bypass stage cleared leaving Capture-DR
// - identification is the default instruction
module jtag_tap_debug_port import tap_pkg::*; #(
   parameter logic [31:0] IDCODE_VALUE = 32'h0000_0FFF  // arbitrary value, lsb one
) (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [3:0] PIN_I,
   output logic [3:0] PIN_O,
   output logic [3:0] PIN_OE,
   output logic [3:0] PIN_PULLUP,
   input wire logic [3:0] GPIO_O,
   input wire logic [3:0] GPIO_OE,
   output logic [3:0] GPIO_I,
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic [3:0] INSTRUCTION,
   output logic RUN_IDLE,
   output logic DEBUG_ENABLED,
   output logic [7:0] BREAK_CONFIG
);
   // ------------------------------------------------------------
   // pins and link edges
   // ------------------------------------------------------------
   logic [3:0] pin_s;
   logic tck_prev_q, tck_rise, tck_fall, tms, tdi;
   logic tpe, dbg_ok, tap_rst;
   logic [3:0] fuse_q, fuse_d;

   sync_2ff #(.W(4)) u_sync (
      .clk(CLOCK),
      .rst(RESET),
      .d(PIN_I),
      .q(pin_s)
   );

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         tck_prev_q <= 1'h0;
      end else begin
         tck_prev_q <= pin_s[PIN_TCK];
      end
   end

   // tms and tdi ride the same two stages as tck, so they stay aligned
   assign tck_rise = pin_s[PIN_TCK] && !tck_prev_q;
   assign tck_fall = !pin_s[PIN_TCK] && tck_prev_q;
   assign tms = pin_s[PIN_TMS];
   assign tdi = pin_s[PIN_TDI];
   assign tpe = fuse_q[FUSE_TPE];
   assign dbg_ok = fuse_q[FUSE_DBG] && !fuse_q[FUSE_LB1] && !fuse_q[FUSE_LB2];
   assign tap_rst = RESET || !tpe;

   // ------------------------------------------------------------
   // controller
   // ------------------------------------------------------------
   tap_state_t state_q, state_d;

   always_comb begin
      state_d = state_q;
      if (tck_rise) begin
         unique case (state_q)
            TLR: state_d = tms ? TLR : RTI;
            RTI: state_d = tms ? SEL_DR : RTI;
            SEL_DR: state_d = tms ? SEL_IR : CAP_DR;
            CAP_DR: state_d = tms ? EX1_DR : SH_DR;
            SH_DR: state_d = tms ? EX1_DR : SH_DR;
            EX1_DR: state_d = tms ? UPD_DR : PAU_DR;
            PAU_DR: state_d = tms ? EX2_DR : PAU_DR;
            EX2_DR: state_d = tms ? UPD_DR : SH_DR;
            UPD_DR: state_d = tms ? SEL_DR : RTI;
            SEL_IR: state_d = tms ? TLR : CAP_IR;
            CAP_IR: state_d = tms ? EX1_IR : SH_IR;
            SH_IR: state_d = tms ? EX1_IR : SH_IR;
            EX1_IR: state_d = tms ? UPD_IR : PAU_IR;
            PAU_IR: state_d = tms ? EX2_IR : PAU_IR;
            EX2_IR: state_d = tms ? UPD_IR : SH_IR;
            UPD_IR: state_d = tms ? SEL_DR : RTI;
            default: state_d = TLR;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (tap_rst) begin
         state_q <= TLR;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // instruction register
   // ------------------------------------------------------------
   logic [3:0] ir_sh_q, ir_sh_d, ir_q, ir_d;

   always_comb begin
      ir_sh_d = ir_sh_q;
      ir_d = ir_q;
      if (tck_rise) begin
         if (state_d == TLR) ir_d = OP_IDCODE;
         if (state_q == CAP_IR) ir_sh_d = IR_CAPTURE;
         if (state_q == SH_IR) ir_sh_d = {tdi, ir_sh_q[3:1]};
         if (state_q == UPD_IR) ir_d = ir_sh_q;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (tap_rst) begin
         ir_sh_q <= IR_CAPTURE;
         ir_q <= OP_IDCODE;
      end else begin
         ir_sh_q <= ir_sh_d;
         ir_q <= ir_d;
      end
   end

   // ------------------------------------------------------------
   // data register selection and shift path
   // ------------------------------------------------------------
   logic sel_id, sel_comm, sel_brk, sel_byp, upd_dr_ev;
   logic [4:0] dr_top;
   logic [31:0] dr_sh_q, dr_sh_d, shifted;
   logic [7:0] brk_q, brk_d;
   logic [6:0] comm_q, comm_d;
   logic dirty_q, dirty_d;

   // private opcodes fall back to bypass while debug is locked out
   assign sel_id = ir_q == OP_IDCODE;
   assign sel_comm = ir_q == OP_COMM && dbg_ok;
   assign sel_brk = ir_q == OP_BRKCFG && dbg_ok;
   assign sel_byp = !sel_id && !sel_comm && !sel_brk;
   assign dr_top = sel_id ? TOP_ID : sel_byp ? TOP_BYP : TOP_BYTE;
   assign upd_dr_ev = tck_rise && state_q == UPD_DR;
   assign shifted = {1'h0, dr_sh_q[31:1]};

   always_comb begin
      dr_sh_d = dr_sh_q;
      brk_d = dbg_ok ? brk_q : '0;
      if (tck_rise && state_q == CAP_DR) begin
         if (sel_id) dr_sh_d = IDCODE_VALUE;
         else if (sel_comm) dr_sh_d = {24'h0, dirty_q, comm_q};
         else if (sel_brk) dr_sh_d = {24'h0, brk_q};
         else dr_sh_d = '0;
      end
      if (tck_rise && state_q == SH_DR) begin
         for (int i = 0; i < 32; i++) begin
            dr_sh_d[i] = (5'(i) == dr_top) ? tdi : shifted[i];
         end
      end
      if (upd_dr_ev && sel_brk) brk_d = dr_sh_q[7:0];
   end

   always_ff @(posedge CLOCK) begin
      if (tap_rst) begin
         dr_sh_q <= '0;
      end else begin
         dr_sh_q <= dr_sh_d;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         brk_q <= '0;
      end else begin
         brk_q <= brk_d;
      end
   end

   // ------------------------------------------------------------
   // test data out, changed on the falling link edge
   // ------------------------------------------------------------
   logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;

   always_comb begin
      tdo_d = tdo_q;
      tdo_oe_d = tdo_oe_q;
      if (tck_fall) begin
         tdo_oe_d = state_q == SH_IR || state_q == SH_DR;
         if (state_q == SH_IR) tdo_d = ir_sh_q[0];
         if (state_q == SH_DR) tdo_d = dr_sh_q[0];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (tap_rst) begin
         tdo_q <= 1'h0;
         tdo_oe_q <= 1'h0;
      end else begin
         tdo_q <= tdo_d;
         tdo_oe_q <= tdo_oe_d;
      end
   end

   // pins fall back to the port when the enable fuse is clear
   assign PIN_O = tpe ? {tdo_q, 3'h0} : GPIO_O;
   assign PIN_OE = tpe ? {tdo_oe_q, 3'h0} : GPIO_OE;
   assign PIN_PULLUP = tpe ? TAP_PULLUPS : 4'h0;
   assign GPIO_I = tpe ? 4'h0 : pin_s;
   assign INSTRUCTION = ir_q;
   assign RUN_IDLE = state_q == RTI;
   assign DEBUG_ENABLED = dbg_ok;
   assign BREAK_CONFIG = brk_q;

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   logic wr_en, wr_hit, rd_hit;
   logic [ADDR_W-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_word;
   logic [3:0] wr_strb;

   axil_slave u_bus (
      .clk(CLOCK), .rst(RESET),
      .awaddr(AWADDR), .awvalid(AWVALID), .awready(AWREADY),
      .wdata(WDATA), .wstrb(WSTRB), .wvalid(WVALID), .wready(WREADY),
      .bresp(BRESP), .bvalid(BVALID), .bready(BREADY),
      .araddr(ARADDR), .arvalid(ARVALID), .arready(ARREADY),
      .rdata(RDATA), .rresp(RRESP), .rvalid(RVALID), .rready(RREADY),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
      .wr_hit(wr_hit), .rd_addr(rd_addr), .rd_hit(rd_hit), .rd_word(rd_word)
   );

   assign wr_hit = wr_addr inside {ADDR_FUSE, ADDR_STATUS, ADDR_COMM, ADDR_BRK};

   always_comb begin
      rd_word = '0;
      rd_hit = 1'h1;
      case (rd_addr)
         ADDR_FUSE: rd_word[3:0] = fuse_q;
         ADDR_STATUS: rd_word = {10'h0, dirty_q, dbg_ok, ir_q, state_q};
         ADDR_COMM: rd_word[7:0] = {dirty_q, comm_q};
         ADDR_BRK: rd_word[7:0] = brk_q;
         default: rd_hit = 1'h0;
      endcase
   end

   always_comb begin
      fuse_d = fuse_q;
      comm_d = comm_q;
      dirty_d = dirty_q;
      if (upd_dr_ev && sel_comm) dirty_d = 1'h0;
      if (wr_en && wr_strb[0]) begin
         if (wr_addr == ADDR_FUSE) fuse_d = wr_data[3:0];
         if (wr_addr == ADDR_COMM) begin
            comm_d = wr_data[6:0];
            dirty_d = 1'h1;  // a new word beats the debugger's clear
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         fuse_q <= FUSE_RESET;
         comm_q <= '0;
         dirty_q <= 1'h0;
      end else begin
         fuse_q <= fuse_d;
         comm_q <= comm_d;
         dirty_q <= dirty_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [2:0] ones_q;

   always_ff @(posedge CLOCK) begin
      if (tap_rst) ones_q <= '0;
      else if (tck_rise) ones_q <= !tms ? 3'h0 : (ones_q == 3'h5) ? ones_q : ones_q + 3'h1;
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   sequence rti_then_one;
      tck_rise && state_q == RTI && tms;
   endsequence

   state_step_a: assert property (rti_then_one |=> state_q == SEL_DR)
      else $error("run-test/idle with tms high did not select dr scan");
   reset_start_a: assert property ($fell(RESET) |-> state_q == TLR)
      else $error("controller not in test-logic-reset after reset");
   five_ones_a: assert property (ones_q == 3'h5 |-> state_q == TLR)
      else $error("five tms-high edges did not reach test-logic-reset");
   ir_capture_a: assert property (tck_rise && state_q == CAP_IR |=> ir_sh_q == IR_CAPTURE)
      else $error("instruction capture value wrong");
   ir_shift_a: assert property (tck_rise && state_q == SH_IR |=>
      ir_sh_q == {$past(tdi), 3'($past(ir_sh_q) >> 1)})
      else $error("instruction shift not lsb first");
   ir_update_a: assert property (tck_rise && state_q == UPD_IR |=> ir_q == $past(ir_sh_q))
      else $error("instruction not loaded in update-ir");
   id_default_a: assert property (state_q == TLR ##1 state_q == RTI |-> ir_q == OP_IDCODE)
      else $error("identification not default after test-logic-reset");
   bypass_clear_a: assert property (tck_rise && state_q == CAP_DR && sel_byp
      |=> dr_sh_q[0] == 1'h0)
      else $error("bypass stage not cleared in capture-dr");
   brk_update_a: assert property ($changed(brk_q) |-> $past(upd_dr_ev) || !$past(dbg_ok))
      else $error("break config changed outside update-dr");
   debug_gate_a: assert property (!dbg_ok |-> (!sel_comm && !sel_brk) ##1 brk_q == 8'h0)
      else $error("debug path open while locked");
   fuse_hold_a: assert property (!tpe |-> PIN_OE == GPIO_OE ##1 state_q == TLR)
      else $error("controller active with port fuse clear");
   tdo_quiet_a: assert property (tck_fall && state_q != SH_IR && state_q != SH_DR
      |=> !tdo_oe_q [*2])
      else $error("tdo driven outside shift states");
endmodule
`default_nettype wire

// [test/jtag_host_model.sv]
// far-side test controller model that drives the link pins
`timescale 1ns/1ns
`default_nettype none
module jtag_host_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   logic tdo_s;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // tck idles low between frames; tms and tdi move only while it is low
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      #40;
      tdo_s = tdo;
      tck = 1'b1;
      #40;
      tck = 1'b0;
   endtask
   // offset keeps link edges away from the system clock edges
   task automatic walk(input logic [15:0] seq, input int n);
      #3;
      for (int i = 0; i < n; i++) begin
         step(seq[i], 1'b0);
      end
   endtask
   // starts and ends in run-idle
   task automatic scan(input logic ir, input logic [31:0] din, input int n,
                       output logic [31:0] dout);
      #3;
      dout = '0;
      step(1'b1, 1'b0);
      if (ir) begin
         step(1'b1, 1'b0);
      end
      step(1'b0, 1'b0);
      step(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i]);
         dout[i] = tdo_s;
      end
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

// [test/tb_jtag_tap_debug_port.sv]
// self-checking bench for the test access port block
`timescale 1ns/1ns
`default_nettype none
module tb_jtag_tap_debug_port import tap_pkg::*; ;
   localparam logic [31:0] ID_VAL = 32'h0ABC_DEF1;  // arbitrary value, lsb one
   logic CLOCK, RESET, RUN_IDLE, DEBUG_ENABLED;
   logic [3:0] PIN_I, PIN_O, PIN_OE, PIN_PULLUP, GPIO_O, GPIO_OE, GPIO_I, WSTRB, INSTRUCTION;
   logic [ADDR_W-1:0] AWADDR, ARADDR;
   logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
   logic [31:0] WDATA, RDATA, d;
   logic [1:0] BRESP, RRESP, r;
   logic [7:0] BREAK_CONFIG, v;
   logic tck, tms, tdi, tdo_last;
   int n_mismatch, check_count, cycles;
   jtag_tap_debug_port #(.IDCODE_VALUE(ID_VAL)) u_dut (
      .CLOCK, .RESET, .PIN_I, .PIN_O, .PIN_OE, .PIN_PULLUP, .GPIO_O, .GPIO_OE, .GPIO_I,
      .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
      .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
      .INSTRUCTION, .RUN_IDLE, .DEBUG_ENABLED, .BREAK_CONFIG);
   jtag_host_model u_host (.tck, .tms, .tdi, .tdo(PIN_I[3]));
   // --------------------------------
   // pin levels
   // --------------------------------
   // released tdo shows the inverse of its last value, never a lucky match
   always_comb begin
      PIN_I = {~tdo_last, tdi, tms, tck};
      for (int k = 0; k < 4; k++) begin
         if (PIN_OE[k]) begin
            PIN_I[k] = PIN_O[k];
         end
      end
   end
   always @(posedge CLOCK) begin
      if (PIN_OE[3]) begin
         tdo_last <= PIN_O[3];
      end
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   always #5 CLOCK = ~CLOCK;
   // --------------------------------
   // tasks
   // --------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dw, input logic [1:0] er);
      logic aw_ok, w_ok, b_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      b_ok = 1'b0;
      @(posedge CLOCK);
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= dw;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!b_ok) begin
         @(posedge CLOCK);
         if (!aw_ok && AWREADY) begin
            aw_ok = 1'b1;
            AWVALID <= 1'b0;
         end
         if (!w_ok && WREADY) begin
            w_ok = 1'b1;
            WVALID <= 1'b0;
         end
         if (BVALID) begin
            b_ok = 1'b1;
            check(BRESP, er);
            BREADY <= 1'b0;
         end
      end
      repeat (2) @(posedge CLOCK);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dr, output logic [1:0] rr);
      logic ar_ok, r_ok;
      ar_ok = 1'b0;
      r_ok = 1'b0;
      @(posedge CLOCK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      while (!r_ok) begin
         @(posedge CLOCK);
         if (!ar_ok && ARREADY) begin
            ar_ok = 1'b1;
            ARVALID <= 1'b0;
         end
         if (RVALID) begin
            r_ok = 1'b1;
            dr = RDATA;
            rr = RRESP;
            RREADY <= 1'b0;
         end
      end
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
      rd(a, d, r);
      check(r, RESP_OKAY);
      check(d, exp);
   endtask
   task automatic scan_chk(input logic ir, input logic [31:0] din, input int n,
                           input logic [31:0] exp);
      u_host.scan(ir, din, n, d);
      check(d, exp);
   endtask
   // --------------------------------
   // main sequence
   // --------------------------------
   initial begin
      {CLOCK, tdo_last, AWADDR, AWVALID, WDATA, WVALID, BREADY, ARADDR, ARVALID, RREADY} = '0;
      {GPIO_O, GPIO_OE, n_mismatch, check_count, cycles} = '0;
      WSTRB = 4'hF;
      RESET = 1'b1;
      repeat (10) @(posedge CLOCK);
      RESET <= 1'b0;
      @(posedge CLOCK);
      check(INSTRUCTION, OP_IDCODE);
      check(PIN_PULLUP, TAP_PULLUPS);
      check(PIN_OE, 4'h0);
      reg_chk(ADDR_STATUS, 32'h0001_0001);
      reg_chk(ADDR_FUSE, 32'h1);
      u_host.walk(16'h0, 1);
      check(RUN_IDLE, 1'b1);
      scan_chk(1'b0, 32'h0, 32, ID_VAL);
      scan_chk(1'b1, OP_BYPASS, 4, IR_CAPTURE);
      check(INSTRUCTION, OP_BYPASS);
      check(PIN_OE[3], 1'b0);
      scan_chk(1'b0, 32'hA5, 8, 32'h4A);
      wr(ADDR_FUSE, 32'h3, RESP_OKAY);
      check(DEBUG_ENABLED, 1'b1);
      scan_chk(1'b1, OP_BRKCFG, 4, IR_CAPTURE);
      for (int m = 0; m < 5; m++) begin
         v = {3'h5, 3'(m), 2'(m + 1)};
         u_host.scan(1'b0, 32'(v), 8, d);
         check(d, (m == 0) ? 32'h0 : 32'({3'h5, 3'(m - 1), 2'(m)}));
         check(BREAK_CONFIG, v);
         reg_chk(ADDR_BRK, 32'(v));
      end
      wr(ADDR_COMM, 32'h55, RESP_OKAY);
      reg_chk(ADDR_STATUS, {10'h0, 2'h3, OP_BRKCFG, 16'h0002});
      scan_chk(1'b1, OP_COMM, 4, IR_CAPTURE);
      scan_chk(1'b0, 32'h0, 8, 32'hD5);
      reg_chk(ADDR_COMM, 32'h55);
      wr(ADDR_FUSE, 32'h7, RESP_OKAY);
      check(DEBUG_ENABLED, 1'b0);
      check(BREAK_CONFIG, 8'h0);
      scan_chk(1'b0, 32'h81, 8, 32'h02);
      wr(ADDR_FUSE, 32'hB, RESP_OKAY);
      check(DEBUG_ENABLED, 1'b0);
      // stay in Shift-IR one period, then five highs from there
      u_host.walk(16'h0003, 5);
      #60;
      check(PIN_OE[3], 1'b1);
      u_host.walk(16'h001F, 5);
      wr(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
      reg_chk(ADDR_STATUS, 32'h0001_0001);
      u_host.walk(16'h0, 1);
      check(RUN_IDLE, 1'b1);
      @(posedge CLOCK);
      GPIO_O <= 4'h2;
      GPIO_OE <= 4'h3;
      wr(ADDR_FUSE, 32'h0, RESP_OKAY);
      repeat (4) @(posedge CLOCK);
      check(RUN_IDLE, 1'b0);
      check(PIN_OE, 4'h3);
      check(PIN_O[1:0], 2'h2);
      check(PIN_PULLUP, 4'h0);
      check(GPIO_I[1:0], 2'h2);
      GPIO_OE <= 4'h0;
      wr(ADDR_FUSE, 32'h1, RESP_OKAY);
      repeat (4) @(posedge CLOCK);
      check(GPIO_I, 4'h0);
      check(PIN_PULLUP, TAP_PULLUPS);
      rd(8'h10, d, r);
      check(r, RESP_SLVERR);
      check(d, 32'h0);
      wr(8'h14, 32'h1, RESP_SLVERR);
      // a write with its low byte lane off must leave the fuses alone
      WSTRB <= 4'h0;
      wr(ADDR_FUSE, 32'h0, RESP_OKAY);
      WSTRB <= 4'hF;
      reg_chk(ADDR_FUSE, 32'h1);
      wr(ADDR_COMM, 32'h12, RESP_OKAY);
      // system reset pulled mid-run, as the debugger may do
      RESET <= 1'b1;
      repeat (3) @(posedge CLOCK);
      RESET <= 1'b0;
      reg_chk(ADDR_STATUS, 32'h0001_0001);
      reg_chk(ADDR_COMM, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
